// ---- abu_pkg.sv ----
package abu_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	localparam int TIMER_COUNT = 2;
	localparam logic [15:0] REG_WAIT_STATUS = 16'hFE00;
	localparam logic [15:0] REG_FLAG_CTRL = 16'hFE03;
	localparam logic [15:0] REG_ADDR_HIGH = 16'hFE0C;
	localparam logic [15:0] REG_ADDR_LOW = 16'hFE0D;
	localparam logic [15:0] REG_STATUS_CTRL = 16'hFE0E;
	localparam logic [15:0] DEV_PAGE = 16'hFE00;
	localparam int BIT_MATCH_ENABLE = 7;
	localparam int BIT_ACTIVE = 6;
	localparam int BIT_WAIT_EXIT = 1;
	localparam int BIT_CLEAR_ENABLE = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
	localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
	localparam logic [11:0] APB_CTRL = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam logic [11:0] APB_DEV_BASE = 12'h100;
	localparam int CTRL_MONITOR = 0;
	localparam int ST_IN_BREAK = 0;
	localparam int ST_BREAK_REQ = 1;
	localparam int ST_CLEAR_ALLOW = 2;
	localparam int ST_PENDING = 3;
	localparam int ST_MONITOR = 4;
	typedef enum logic [1:0] {
		ABU_IDLE = 2'b00,
		ABU_PEND = 2'b01,
		ABU_BRK = 2'b10
	} abu_state_t;
endpackage : abu_pkg

// ---- abu_link_if.sv ----
`timescale 1ns/1ps
interface abu_link_if;
	logic [15:0] bus_addr;
	logic bus_cycle;
	logic bus_opcode;
	logic bus_wait;
	logic in_break;
	logic reg_wr;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic break_req;
	logic break_opcode;
	logic status_clear_allow;
	modport dev (
		input bus_addr,
		input bus_cycle,
		input bus_opcode,
		input bus_wait,
		input in_break,
		input reg_wr,
		input reg_addr,
		input reg_wdata,
		output reg_rdata,
		output break_req,
		output break_opcode,
		output status_clear_allow
	);
	modport sim (
		output bus_addr,
		output bus_cycle,
		output bus_opcode,
		output bus_wait,
		output in_break,
		output reg_wr,
		output reg_addr,
		output reg_wdata,
		input reg_rdata,
		input break_req,
		input break_opcode,
		input status_clear_allow
	);
endinterface : abu_link_if

// ---- abu_addr_match.sv ----
`timescale 1ns/1ps
module abu_addr_match #(
	parameter int ADDR_W = abu_pkg::ADDR_W
) (
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [ADDR_W-1:0] brk_addr,
	input wire logic arm,
	input wire logic cycle,
	output logic match
);
	// Every bus cycle is compared on all address bits.
	assign match = arm & cycle & (addr == brk_addr);
endmodule : abu_addr_match

// ---- abu_break_unit.sv ----
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module abu_break_unit #(
	parameter int ADDR_W = abu_pkg::ADDR_W,
	parameter int TIMER_COUNT = abu_pkg::TIMER_COUNT
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic test_high_voltage,
	abu_link_if.dev link,
	output logic [TIMER_COUNT-1:0] timer_halt,
	output logic watchdog_disable
);
	logic match_break_enable;
	logic break_active_flag;
	logic [7:0] break_address_high_byte;
	logic [7:0] break_address_low_byte;
	logic wait_exit_by_break_flag;
	logic break_flag_clear_enable;
	logic pending;
	logic pending_opcode;
	logic hold_off;
	logic tv_meta;
	logic tv_sync;
	logic [7:0] rdata;
	logic clear_allow;

	logic next_match_break_enable;
	logic next_break_active_flag;
	logic [7:0] next_high;
	logic [7:0] next_low;
	logic next_wait_flag;
	logic next_clear_enable;
	logic next_pending;
	logic next_pending_opcode;
	logic next_hold_off;
	logic [7:0] next_rdata;

	wire [15:0] break_addr;
	wire hit_wait;
	wire hit_flag;
	wire hit_high;
	wire hit_low;
	wire hit_sc;
	wire wr_wait;
	wire wr_flag;
	wire wr_high;
	wire wr_low;
	wire wr_sc;
	wire sw_break;
	wire match;
	wire arm;
	wire [7:0] rd_wait;
	wire [7:0] rd_flag;
	wire [7:0] rd_sc;

	function automatic logic reg_hit(
		input logic [15:0] a,
		input logic [15:0] r
	);
		reg_hit = (a == r);
	endfunction : reg_hit

	assign hit_wait = reg_hit(link.reg_addr, abu_pkg::REG_WAIT_STATUS);
	assign hit_flag = reg_hit(link.reg_addr, abu_pkg::REG_FLAG_CTRL);
	assign hit_high = reg_hit(link.reg_addr, abu_pkg::REG_ADDR_HIGH);
	assign hit_low = reg_hit(link.reg_addr, abu_pkg::REG_ADDR_LOW);
	assign hit_sc = reg_hit(link.reg_addr, abu_pkg::REG_STATUS_CTRL);
	assign wr_wait = link.reg_wr & hit_wait;
	assign wr_flag = link.reg_wr & hit_flag;
	assign wr_high = link.reg_wr & hit_high;
	assign wr_low = link.reg_wr & hit_low;
	assign wr_sc = link.reg_wr & hit_sc;

	assign break_addr = {break_address_high_byte, break_address_low_byte};

	// A set active flag also blocks matching, so one hit raises one break.
	assign arm = match_break_enable & ~hold_off & ~break_active_flag;

	// Wait mode does not gate the comparator.
	abu_addr_match #(
		.ADDR_W(ADDR_W)
	) u_match (
		.addr(link.bus_addr),
		.brk_addr(break_addr),
		.arm(arm),
		.cycle(link.bus_cycle),
		.match(match)
	);

	assign sw_break = wr_sc & link.reg_wdata[abu_pkg::BIT_ACTIVE];

	always_comb begin
		next_break_active_flag = break_active_flag;
		if (match | sw_break) begin
			next_break_active_flag = 1'b1;
		end else if (wr_sc) begin
			next_break_active_flag = 1'b0;
		end
	end

	assign next_match_break_enable = wr_sc ?
		link.reg_wdata[abu_pkg::BIT_MATCH_ENABLE] : match_break_enable;
	assign next_high = wr_high ? link.reg_wdata : break_address_high_byte;
	assign next_low = wr_low ? link.reg_wdata : break_address_low_byte;
	assign next_clear_enable = wr_flag ?
		link.reg_wdata[abu_pkg::BIT_CLEAR_ENABLE] : break_flag_clear_enable;

	// Clearing the active flag alone does not re-arm; a new address does.
	always_comb begin
		next_hold_off = hold_off;
		if (match) begin
			next_hold_off = 1'b1;
		end else if (wr_high | wr_low) begin
			next_hold_off = 1'b0;
		end
	end

	// The request stands until the integration logic enters the break.
	always_comb begin
		next_pending = pending;
		next_pending_opcode = pending_opcode;
		if (match) begin
			next_pending = 1'b1;
			next_pending_opcode = link.bus_opcode;
		end else if (sw_break) begin
			next_pending = 1'b1;
			next_pending_opcode = 1'b0;
		end else if (link.in_break) begin
			next_pending = 1'b0;
			next_pending_opcode = 1'b0;
		end
	end

	// A break pending while the core waits is the one that ends the wait.
	always_comb begin
		next_wait_flag = wait_exit_by_break_flag;
		if (pending & link.bus_wait) begin
			next_wait_flag = 1'b1;
		end else if (wr_wait & ~link.reg_wdata[abu_pkg::BIT_WAIT_EXIT]) begin
			next_wait_flag = 1'b0;
		end
	end

	assign rd_wait = {6'h00, wait_exit_by_break_flag, 1'b0};
	assign rd_flag = {break_flag_clear_enable, 7'h00};
	assign rd_sc = {match_break_enable, break_active_flag, 6'h00};
	assign next_rdata = hit_wait ? rd_wait :
		hit_flag ? rd_flag :
		hit_high ? break_address_high_byte :
		hit_low ? break_address_low_byte :
		hit_sc ? rd_sc :
		abu_pkg::RST_BYTE;

	// The pin is asynchronous to clk, so it is resynchronised first.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tv_meta <= 1'b0;
			tv_sync <= 1'b0;
		end else if (ce) begin
			tv_meta <= test_high_voltage;
			tv_sync <= tv_meta;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			match_break_enable <= 1'b0;
			break_active_flag <= 1'b0;
			break_address_high_byte <= abu_pkg::RST_BYTE;
			break_address_low_byte <= abu_pkg::RST_BYTE;
			break_flag_clear_enable <= 1'b0;
			wait_exit_by_break_flag <= 1'b0;
			hold_off <= 1'b0;
		end else if (ce) begin
			match_break_enable <= next_match_break_enable;
			break_active_flag <= next_break_active_flag;
			break_address_high_byte <= next_high;
			break_address_low_byte <= next_low;
			break_flag_clear_enable <= next_clear_enable;
			wait_exit_by_break_flag <= next_wait_flag;
			hold_off <= next_hold_off;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pending <= 1'b0;
			pending_opcode <= 1'b0;
			rdata <= abu_pkg::RST_BYTE;
			clear_allow <= 1'b1;
			timer_halt <= '0;
			watchdog_disable <= 1'b0;
		end else if (ce) begin
			pending <= next_pending;
			pending_opcode <= next_pending_opcode;
			rdata <= next_rdata;
			clear_allow <= ~link.in_break | break_flag_clear_enable;
			timer_halt <= {TIMER_COUNT{link.in_break}};
			watchdog_disable <= link.in_break & tv_sync;
		end
	end

	assign link.break_req = pending;
	assign link.break_opcode = pending_opcode;
	assign link.reg_rdata = rdata;
	assign link.status_clear_allow = clear_allow;
endmodule : abu_break_unit

// ---- abu_sim_ctrl.sv ----
`timescale 1ns/1ps
module abu_sim_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_cycle,
	input wire logic cpu_opcode,
	input wire logic cpu_instr_done,
	input wire logic cpu_wait,
	input wire logic cpu_rti,
	output logic swi_load,
	output logic [15:0] vector_addr,
	output logic wake,
	abu_link_if.sim link
);
	abu_pkg::abu_state_t state;
	abu_pkg::abu_state_t next_state;
	logic monitor_mode;
	logic next_swi;

	wire access;
	wire hit_ctrl;
	wire hit_status;
	wire hit_dev;
	wire [31:0] status_word;

	assign access = psel & penable;
	assign hit_ctrl = paddr == abu_pkg::APB_CTRL;
	assign hit_status = paddr == abu_pkg::APB_STATUS;
	assign hit_dev = paddr[11:6] == abu_pkg::APB_DEV_BASE[11:6];

	// The break unit registers its read data each cycle from the address
	// presented in setup, so every access completes without wait states.
	assign pready = 1'b1;
	assign pslverr = access & ~(hit_ctrl | hit_status | hit_dev);

	assign link.bus_addr = cpu_addr;
	assign link.bus_cycle = cpu_cycle;
	assign link.bus_opcode = cpu_opcode;
	assign link.bus_wait = cpu_wait;
	assign link.in_break = state == abu_pkg::ABU_BRK;
	assign link.reg_wr = access & pwrite & hit_dev;
	assign link.reg_addr = abu_pkg::DEV_PAGE | {12'h000, paddr[5:2]};
	assign link.reg_wdata = pwdata[7:0];

	assign status_word = {27'h000_0000, monitor_mode,
		state == abu_pkg::ABU_PEND, link.status_clear_allow,
		link.break_req, link.in_break};
	assign prdata = hit_ctrl ? {31'h0000_0000, monitor_mode} :
		hit_status ? status_word :
		hit_dev ? {24'h00_0000, link.reg_rdata} :
		32'h0000_0000;

	// A break request ends wait mode.
	assign wake = link.break_req & cpu_wait;

	always_comb begin
		next_state = state;
		case (state)
			abu_pkg::ABU_IDLE: begin
				if (link.break_req & link.break_opcode) begin
					next_state = abu_pkg::ABU_BRK;
				end else if (link.break_req) begin
					next_state = abu_pkg::ABU_PEND;
				end
			end
			abu_pkg::ABU_PEND: begin
				if (cpu_instr_done) begin
					next_state = abu_pkg::ABU_BRK;
				end
			end
			abu_pkg::ABU_BRK: begin
				if (cpu_rti) begin
					next_state = abu_pkg::ABU_IDLE;
				end
			end
			default: begin
				next_state = abu_pkg::ABU_IDLE;
			end
		endcase
	end

	assign next_swi = (state != abu_pkg::ABU_BRK) &
		(next_state == abu_pkg::ABU_BRK);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= abu_pkg::ABU_IDLE;
			monitor_mode <= 1'b0;
			swi_load <= 1'b0;
			vector_addr <= abu_pkg::VEC_NORMAL;
		end else if (ce) begin
			state <= next_state;
			if (access & pwrite & hit_ctrl) begin
				monitor_mode <= pwdata[abu_pkg::CTRL_MONITOR];
			end
			swi_load <= next_swi;
			if (next_swi) begin
				vector_addr <= monitor_mode ?
					abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL;
			end
		end
	end
endmodule : abu_sim_ctrl

// ---- abu_assertions.sv ----
`timescale 1ns/1ps
module abu_assertions (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] bus_addr,
	input wire logic bus_cycle,
	input wire logic bus_opcode,
	input wire logic in_break,
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic break_req,
	input wire logic break_opcode,
	input wire logic status_clear_allow,
	input wire logic [1:0] timer_halt,
	input wire logic watchdog_disable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Shadow copies of the device registers, so no check peeks inside.
	logic sh_en;
	logic sh_cfe;
	logic [15:0] sh_adr;
	wire sw_brk = reg_wr && reg_addr == 16'hFE0E && reg_wdata[6];
	wire hit = bus_cycle && sh_en && bus_addr == sh_adr;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh_en <= 1'b0;
			sh_cfe <= 1'b0;
			sh_adr <= 16'h0000;
		end else if (reg_wr) begin
			case (reg_addr)
			16'hFE0E: sh_en <= reg_wdata[7];
			16'hFE03: sh_cfe <= reg_wdata[7];
			16'hFE0C: sh_adr[15:8] <= reg_wdata;
			16'hFE0D: sh_adr[7:0] <= reg_wdata;
			default: ;
			endcase
		end
	end
	sequence s_enter;
		!in_break ##1 in_break;
	endsequence
	sequence s_leave;
		in_break ##1 !in_break;
	endsequence
	a_sw_break: assert property (sw_brk |=> break_req)
		else $error("software break not requested");
	a_req_cause: assert property ($rose(break_req) |-> $past(sw_brk || hit))
		else $error("break request without cause");
	a_req_kind: assert property ($rose(break_req)
		|-> break_opcode == $past(hit && bus_opcode && !sw_brk))
		else $error("break kind wrong");
	a_req_holds: assert property (break_req && !in_break |=> break_req)
		else $error("break request dropped early");
	a_timers_halt: assert property (s_enter |=> timer_halt == 2'b11)
		else $error("timers not halted");
	a_timers_run: assert property (s_leave |=> timer_halt == 2'b00)
		else $error("timers not released");
	a_watchdog_off: assert property (watchdog_disable |-> $past(in_break))
		else $error("watchdog off outside break");
	a_clear_locked: assert property (in_break && !sh_cfe |=> !status_clear_allow)
		else $error("status clear allowed in break");
	a_clear_free: assert property (!in_break || sh_cfe |=> status_clear_allow)
		else $error("status clear blocked");
endmodule : abu_assertions

// ---- address_breakpoint_unit_tb.sv ----
`timescale 1ns/1ps
module address_breakpoint_unit_tb;
	logic clk, nrst = 1'b0, ce = 1'b1, test_high_voltage = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [15:0] cpu_addr = 16'h0000, vector_addr;
	logic cpu_cycle = 1'b0, cpu_opcode = 1'b0, cpu_instr_done = 1'b0;
	logic cpu_wait = 1'b0, cpu_rti = 1'b0, swi_load, wake, perr;
	logic [1:0] timer_halt;
	logic watchdog_disable;
	int bad_count = 0, num_checks = 0;
	abu_link_if lk ();
	abu_sim_ctrl u_abu_sim_ctrl (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cpu_addr(cpu_addr),
		.cpu_cycle(cpu_cycle),
		.cpu_opcode(cpu_opcode),
		.cpu_instr_done(cpu_instr_done),
		.cpu_wait(cpu_wait),
		.cpu_rti(cpu_rti),
		.swi_load(swi_load),
		.vector_addr(vector_addr),
		.wake(wake),
		.link(lk.sim)
	);
	abu_break_unit u_abu_break_unit (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.test_high_voltage(test_high_voltage),
		.link(lk.dev),
		.timer_halt(timer_halt),
		.watchdog_disable(watchdog_disable)
	);
	abu_assertions u_abu_assertions (.clk(clk), .nrst(nrst),
		.bus_addr(lk.bus_addr), .bus_cycle(lk.bus_cycle),
		.bus_opcode(lk.bus_opcode), .in_break(lk.in_break),
		.reg_wr(lk.reg_wr), .reg_addr(lk.reg_addr),
		.reg_wdata(lk.reg_wdata), .break_req(lk.break_req),
		.break_opcode(lk.break_opcode), .timer_halt(timer_halt),
		.status_clear_allow(lk.status_clear_allow),
		.watchdog_disable(watchdog_disable));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task results;
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task fail(input string n);
		bad_count++;
		$display("Error %s timed out, exp 1 got 0", n);
		results();
	endtask : fail
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
			fail("pready");
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, rdat);
	endtask : rc
	task cyc(input logic [15:0] a, input logic op);
		@(posedge clk);
		cpu_addr <= a;
		cpu_cycle <= 1'b1;
		cpu_opcode <= op;
		@(posedge clk);
		cpu_cycle <= 1'b0;
		cpu_opcode <= 1'b0;
		cpu_addr <= ~a;
	endtask : cyc
	task pulse(input logic r);
		@(posedge clk);
		cpu_rti <= r;
		cpu_instr_done <= !r;
		@(posedge clk);
		cpu_rti <= 1'b0;
		cpu_instr_done <= 1'b0;
	endtask : pulse
	task swi_wait(input logic [15:0] v);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (swi_load !== 1'b1 && i < 20);
		if (swi_load !== 1'b1)
			fail("swi_load");
		chk("vector_addr", 32'(v), 32'(vector_addr));
	endtask : swi_wait
	task quiet(input int n);
		repeat (n) begin
			@(posedge clk);
			chk("swi_load", 32'h0, 32'(swi_load));
		end
	endtask : quiet
	task t_reset;
		rc(12'h100, 32'h0);
		rc(12'h10C, 32'h0);
		rc(12'h130, 32'h0);
		rc(12'h134, 32'h0);
		rc(12'h138, 32'h0);
		rc(12'h004, 32'h4);
		apb(1'b0, 12'h040, 32'h0);
		chk("pslverr", 32'h1, 32'(perr));
		// With the clock enable low a register write must not land.
		ce <= 1'b0;
		apb(1'b1, 12'h130, 32'hAA);
		ce <= 1'b1;
		rc(12'h130, 32'h0);
	endtask : t_reset
	task t_opcode;
		apb(1'b1, 12'h130, 32'h12);
		apb(1'b1, 12'h134, 32'h34);
		apb(1'b1, 12'h138, 32'h80);
		cyc(16'h1234, 1'b1);
		swi_wait(16'hFFFC);
		@(posedge clk);
		chk("timer_halt", 32'h3, 32'(timer_halt));
		chk("watchdog", 32'h0, 32'(watchdog_disable));
		rc(12'h138, 32'hC0);
		apb(1'b1, 12'h138, 32'h80);
		pulse(1'b1);
		repeat (3) @(posedge clk);
		chk("timer_halt", 32'h0, 32'(timer_halt));
		rc(12'h004, 32'h4);
		cyc(16'h1234, 1'b1);
		quiet(6);
		rc(12'h138, 32'h80);
	endtask : t_opcode
	task t_operand;
		apb(1'b1, 12'h138, 32'h0);
		apb(1'b1, 12'h134, 32'h35);
		cyc(16'h1235, 1'b1);
		quiet(6);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b1, 12'h138, 32'h80);
		cyc(16'h1235, 1'b0);
		quiet(4);
		rc(12'h004, 32'h1E);
		pulse(1'b0);
		swi_wait(16'hFEFC);
		apb(1'b1, 12'h138, 32'h80);
		pulse(1'b1);
		apb(1'b1, 12'h000, 32'h0);
	endtask : t_operand
	task t_wait;
		test_high_voltage <= 1'b1;
		cpu_wait <= 1'b1;
		apb(1'b1, 12'h138, 32'h40);
		@(posedge clk);
		chk("wake", 32'h1, 32'(wake));
		pulse(1'b0);
		swi_wait(16'hFFFC);
		cpu_wait <= 1'b0;
		repeat (2) @(posedge clk);
		chk("watchdog", 32'h1, 32'(watchdog_disable));
		rc(12'h100, 32'h2);
		rc(12'h004, 32'h1);
		apb(1'b1, 12'h10C, 32'h80);
		rc(12'h004, 32'h5);
		apb(1'b1, 12'h100, 32'h0);
		rc(12'h100, 32'h0);
		apb(1'b1, 12'h138, 32'h0);
		pulse(1'b1);
		test_high_voltage <= 1'b0;
	endtask : t_wait
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_opcode();
		t_operand();
		t_wait();
		results();
	end
endmodule : address_breakpoint_unit_tb
